/* hdl/supervisor_pkg.sv */
// Shared constants, types and the exit request decode for the alarm input supervisor.
// Assumes one 250 MHz core clock and an APB slave with 32-bit data.
package supervisor_pkg;

	// Clock and door time unit
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int NUM_INPUTS_DEF = 8;
	localparam int TIME_W = 16;
	localparam int FAULT_W = 3;
	localparam int MODE_W = 4;
	localparam int EV_W = 10;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [7:0] ADDR_ENABLE = 8'h00;
	localparam logic [7:0] ADDR_POLARITY = 8'h04;
	localparam logic [7:0] ADDR_REPORT = 8'h08;
	localparam logic [7:0] ADDR_EXIT_MODE = 8'h0c;
	localparam logic [7:0] ADDR_CODE_MASK = 8'h10;
	localparam logic [7:0] ADDR_DOOR_TIME = 8'h14;
	localparam logic [7:0] ADDR_COMMAND = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;

	// Reset values
	localparam logic [TIME_W-1:0] DOOR_TIME_RESET = 16'h1388;
	localparam logic [MODE_W-1:0] EXIT_MODE_RESET = 4'h5;

	// Command word layout and operations
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_MODE_LSB = 4;
	localparam int CMD_DIGIT_LSB = 8;
	localparam int CMD_DIGITS = 6;
	localparam logic [3:0] OP_ENABLE = 4'h1;
	localparam logic [3:0] OP_DISABLE = 4'h2;
	localparam logic [3:0] OP_NORM_OPEN = 4'h3;
	localparam logic [3:0] OP_NORM_CLOSED = 4'h4;
	localparam logic [3:0] OP_EXIT_MODE = 4'h5;
	localparam logic [3:0] OP_REPORT_DOOR = 4'h6;
	localparam logic [3:0] OP_REPORT_ALARM = 4'h7;

	////////////////////////////////////////////////////////////////////////////////
	// Event codes, also the bit index of each pending flag
	localparam logic [3:0] EV_SECURE = 4'h0;
	localparam logic [3:0] EV_FORCED = 4'h1;
	localparam logic [3:0] EV_HELD = 4'h2;
	localparam logic [3:0] EV_EXIT = 4'h3;
	localparam logic [3:0] EV_LINE_OPEN = 4'h4;
	localparam logic [3:0] EV_ALARM_OPEN = 4'h8;
	localparam logic [3:0] EV_TOO_LONG = 4'h9;

	typedef enum logic [0:0] {EXIT_IDLE = 1'b0, EXIT_HELD = 1'b1} exit_state_t;
	typedef struct packed {
		logic act;
		logic relay;
		logic retrig;
	} exit_action_t;

	// Exit request mode code to action
	function automatic exit_action_t exit_decode(input logic [MODE_W-1:0] code);
		exit_action_t a;
		a = '0;
		case (code)
			4'h1, 4'h4, 4'h6: a = '{act: 1'b1, relay: 1'b1, retrig: 1'b0};
			4'h2, 4'h7: a = '{act: 1'b1, relay: 1'b0, retrig: 1'b0};
			4'h3, 4'h8: a = '{act: 1'b1, relay: 1'b1, retrig: 1'b1};
			4'h9: a = '{act: 1'b1, relay: 1'b0, retrig: 1'b1};
			default: a = '0;
		endcase
		return a;
	endfunction : exit_decode

endpackage : supervisor_pkg

/* hdl/input_channel.sv */
// One supervised input: pin synchronisers, secure tracking, exit request and mask timer.
// Assumes the door time tick is a one-cycle enable from the parent.
module input_channel
	import supervisor_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic enable,
	input wire logic polarity,
	input wire logic [supervisor_pkg::MODE_W-1:0] exit_mode,
	input wire logic [supervisor_pkg::TIME_W-1:0] door_time,
	input wire logic ext_mask,
	input wire logic held_open_timeout,
	input wire logic contact_closed,
	input wire logic exit_request,
	input wire logic [supervisor_pkg::FAULT_W-1:0] line_fault,
	output logic masked,
	output logic secure,
	output logic [supervisor_pkg::FAULT_W-1:0] fault,
	output logic relay_trigger,
	output logic ev_secure,
	output logic ev_open,
	output logic ev_held,
	output logic ev_exit,
	output logic ev_fault
);
	typedef struct packed {
		logic [2:0] c_sync;
		logic contact;
		logic [2:0] x_sync;
		logic exit_on;
		logic [2:0][FAULT_W-1:0] f_sync;
		logic [FAULT_W-1:0] fault;
		logic [FAULT_W-1:0] fault_seen;
		exit_state_t st;
		logic [TIME_W-1:0] timer;
		logic secure;
		logic relay;
		logic ev_secure;
		logic ev_open;
		logic ev_held;
		logic ev_exit;
		logic ev_fault;
	} chan_t;

	chan_t q;
	chan_t next_q;
	exit_action_t act;
	logic now_secure;

	assign act = exit_decode(exit_mode);
	assign now_secure = q.contact ^ polarity;
	assign masked = ext_mask | (q.timer != '0);
	assign secure = q.secure;
	assign fault = q.fault;
	assign relay_trigger = q.relay;
	assign ev_secure = q.ev_secure;
	assign ev_open = q.ev_open;
	assign ev_held = q.ev_held;
	assign ev_exit = q.ev_exit;
	assign ev_fault = q.ev_fault;

	// Synchronisers, event detection and exit request sequencing
	always_comb begin
		next_q = q;
		next_q.c_sync = {q.c_sync[1:0], contact_closed};
		next_q.x_sync = {q.x_sync[1:0], exit_request};
		next_q.f_sync = {q.f_sync[1:0], line_fault};
		if (q.c_sync[1] == q.c_sync[2]) begin
			next_q.contact = q.c_sync[1];
		end
		if (q.x_sync[1] == q.x_sync[2]) begin
			next_q.exit_on = q.x_sync[1];
		end
		if (q.f_sync[1] == q.f_sync[2]) begin
			next_q.fault = q.f_sync[1];
		end
		{next_q.relay, next_q.ev_secure, next_q.ev_open} = 3'h0;
		{next_q.ev_held, next_q.ev_exit, next_q.ev_fault} = 3'h0;
		if (tick && q.timer != '0) begin
			next_q.timer = q.timer - 1'b1;
		end
		if (!enable) begin
			// Disabled input stays silent and ignores exit requests
			next_q.secure = now_secure;
			next_q.fault_seen = q.fault;
			next_q.st = EXIT_IDLE;
			next_q.timer = '0;
		end else begin
			if (now_secure != q.secure) begin
				next_q.secure = now_secure;
				next_q.ev_secure = now_secure;
				next_q.ev_open = !now_secure && !masked;
			end
			if (q.fault != q.fault_seen) begin
				next_q.fault_seen = q.fault;
				next_q.ev_fault = (q.fault != '0);
			end
			next_q.ev_held = held_open_timeout;
			case (q.st)
				EXIT_IDLE: begin
					if (q.exit_on && act.act) begin
						next_q.st = EXIT_HELD;
						next_q.timer = door_time;
						next_q.relay = act.relay;
						next_q.ev_exit = 1'b1;
					end
				end
				EXIT_HELD: begin
					if (!q.exit_on) begin
						next_q.st = EXIT_IDLE;
					end else if (act.retrig && tick) begin
						next_q.timer = door_time;
						next_q.relay = act.relay;
					end
				end
				default: next_q.st = EXIT_IDLE;
			endcase
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{c_sync: 3'h7, contact: 1'b1, secure: 1'b1, st: EXIT_IDLE, default: '0};
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_open_unmasked;
		@(posedge core_clk) disable iff (!rst_n) q.ev_open |-> !$past(masked);
	endproperty
	a_open_unmasked: assert property (p_open_unmasked) else $error("open report while masked");

	property p_exit_loads;
		@(posedge core_clk) disable iff (!rst_n) q.ev_exit |-> q.timer == $past(door_time);
	endproperty
	a_exit_loads: assert property (p_exit_loads) else $error("exit did not load door time");

	property p_relay_mode;
		@(posedge core_clk) disable iff (!rst_n) q.relay |-> $past(act.relay && enable);
	endproperty
	a_relay_mode: assert property (p_relay_mode) else $error("relay pulse in mask-only mode");

	property p_retrigger;
		@(posedge core_clk) disable iff (!rst_n)
			(enable && q.st == EXIT_HELD && q.exit_on && act.retrig && tick) |=> q.timer == $past(door_time);
	endproperty
	a_retrigger: assert property (p_retrigger) else $error("retrigger missed");

	property p_once;
		@(posedge core_clk) disable iff (!rst_n)
			(q.st == EXIT_HELD && !act.retrig && $stable(exit_mode)) |=> !q.ev_exit && !q.relay;
	endproperty
	a_once: assert property (p_once) else $error("once mode fired twice");

	c_exit_granted: cover property (@(posedge core_clk) disable iff (!rst_n) q.ev_exit);
endmodule : input_channel

/* hdl/alarm_input_supervisor.sv */
// Alarm input supervisor top: APB registers, command decode, per-input channels, event queue.
// Assumes an APB3 master on core_clk and line module pins asynchronous to it.
//
// What this block does
// - An input set for alarm reporting turns forced-door into alarm-open and held-open into too-long.
// - An exit request activation masks its input for the configured door time.
// - An input counts as masked under time zone, masking code or an actuated relay.
// - Masking suppresses only the forced-door or alarm-open report and nothing else.
// - The enable command takes a list of input digits, each digit selecting one input.
// - Any subset of inputs may be disabled.
// - A disabled input reports nothing and its exit request is ignored.
// - Inputs are normally closed when secure by default, and polarity code 1 makes them open.
// - Exit mode 1 triggers the relay and masks, 2 only masks, 5 turns handling off.
// - Exit mode 3 retriggers while the request is active, 4 acts once per activation.
// - Modes 6 and 7 act once per activation, 8 and 9 retrigger while active, with or without relay.
// - Every input is enabled out of reset.
// - Door inputs report secure, forced, held open, exit granted, open, short, noise, out of spec.
//
// Added by the designer: the APB slave port and the address map.
module alarm_input_supervisor #(
	parameter int NUM_INPUTS = supervisor_pkg::NUM_INPUTS_DEF,
	parameter int TICK_CYCLES = supervisor_pkg::TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_INPUTS-1:0] contact_closed,
	input wire logic [NUM_INPUTS-1:0] exit_request,
	input wire logic [NUM_INPUTS*supervisor_pkg::FAULT_W-1:0] line_fault,
	input wire logic [NUM_INPUTS-1:0] tz_mask,
	input wire logic [NUM_INPUTS-1:0] relay_actuated,
	input wire logic [NUM_INPUTS-1:0] held_open_timeout,
	output logic [NUM_INPUTS-1:0] relay_trigger,
	output logic [NUM_INPUTS-1:0] input_masked,
	output logic event_valid,
	output logic [$clog2(NUM_INPUTS)-1:0] event_input,
	output logic [3:0] event_code
);
	import supervisor_pkg::*;

	localparam int N = NUM_INPUTS;
	localparam int IW = $clog2(NUM_INPUTS);
	localparam int TW = $clog2(TICK_CYCLES);

	typedef struct packed {
		logic [N-1:0] enable;
		logic [N-1:0] polarity;
		logic [N-1:0] report_alarm;
		logic [N-1:0] code_mask;
		logic [N*MODE_W-1:0] exit_mode;
		logic [TIME_W-1:0] door_time;
		logic [31:0] prdata;
		logic [TW-1:0] tick_cnt;
		logic tick;
		logic [N-1:0][EV_W-1:0] pend;
		logic [IW-1:0] ptr;
		logic ev_valid;
		logic [IW-1:0] ev_input;
		logic [3:0] ev_code;
	} top_t;

	top_t q;
	top_t next_q;
	logic [N-1:0] ch_secure;
	logic [N-1:0] ch_relay;
	logic [N-1:0] ch_ev_secure;
	logic [N-1:0] ch_ev_open;
	logic [N-1:0] ch_ev_held;
	logic [N-1:0] ch_ev_exit;
	logic [N-1:0] ch_ev_fault;
	logic [N-1:0][FAULT_W-1:0] ch_fault;
	logic wr;
	logic rd_setup;
	logic hit;
	logic [31:0] rd_val;
	logic [N-1:0] sel;
	logic [3:0] cmd_op;
	logic [MODE_W-1:0] cmd_mode;

	////////////////////////////////////////////////////////////////////////////////
	// APB handshake
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~hit;
	assign prdata = q.prdata;
	assign cmd_op = pwdata[CMD_OP_LSB +: 4];
	assign cmd_mode = pwdata[CMD_MODE_LSB +: MODE_W];
	assign relay_trigger = ch_relay;
	assign event_valid = q.ev_valid;
	assign event_input = q.ev_input;
	assign event_code = q.ev_code;

	// Address decode and read data
	always_comb begin
		hit = 1'b1;
		rd_val = '0;
		if (paddr == ADDR_ENABLE) begin
			rd_val[N-1:0] = q.enable;
		end else if (paddr == ADDR_POLARITY) begin
			rd_val[N-1:0] = q.polarity;
		end else if (paddr == ADDR_REPORT) begin
			rd_val[N-1:0] = q.report_alarm;
		end else if (paddr == ADDR_EXIT_MODE) begin
			rd_val[N*MODE_W-1:0] = q.exit_mode;
		end else if (paddr == ADDR_CODE_MASK) begin
			rd_val[N-1:0] = q.code_mask;
		end else if (paddr == ADDR_DOOR_TIME) begin
			rd_val[TIME_W-1:0] = q.door_time;
		end else if (paddr == ADDR_COMMAND) begin
			rd_val = '0;
		end else if (paddr == ADDR_STATUS) begin
			rd_val[2*N-1:0] = {input_masked, ch_secure};
		end else begin
			hit = 1'b0;
		end
	end

	// Digit list of a command selects inputs
	always_comb begin
		logic [3:0] digit;
		digit = '0;
		sel = '0;
		for (int d = 0; d < CMD_DIGITS; d++) begin
			digit = pwdata[CMD_DIGIT_LSB + 4*d +: 4];
			for (int i = 0; i < N; i++) begin
				if (digit == 4'(i + 1)) begin
					sel[i] = 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state: registers, commands, tick divider, event queue
	always_comb begin
		logic found;
		logic [3:0] code;
		found = 1'b0;
		code = '0;
		next_q = q;
		// Door time unit tick
		next_q.tick = 1'b0;
		if (q.tick_cnt == TW'(TICK_CYCLES - 1)) begin
			next_q.tick_cnt = '0;
			next_q.tick = 1'b1;
		end else begin
			next_q.tick_cnt = q.tick_cnt + 1'b1;
		end
		// Read data captured in the setup phase
		if (rd_setup) begin
			next_q.prdata = rd_val;
		end
		// Direct register writes, taken in the access phase
		if (wr) begin
			if (paddr == ADDR_ENABLE) begin
				next_q.enable = pwdata[N-1:0];
			end else if (paddr == ADDR_POLARITY) begin
				next_q.polarity = pwdata[N-1:0];
			end else if (paddr == ADDR_REPORT) begin
				next_q.report_alarm = pwdata[N-1:0];
			end else if (paddr == ADDR_EXIT_MODE) begin
				next_q.exit_mode = pwdata[N*MODE_W-1:0];
			end else if (paddr == ADDR_CODE_MASK) begin
				next_q.code_mask = pwdata[N-1:0];
			end else if (paddr == ADDR_DOOR_TIME) begin
				next_q.door_time = pwdata[TIME_W-1:0];
			end else if (paddr == ADDR_COMMAND) begin
				case (cmd_op)
					OP_ENABLE: next_q.enable = q.enable | sel;
					OP_DISABLE: next_q.enable = q.enable & ~sel;
					OP_NORM_OPEN: next_q.polarity = q.polarity | sel;
					OP_NORM_CLOSED: next_q.polarity = q.polarity & ~sel;
					OP_REPORT_DOOR: next_q.report_alarm = q.report_alarm & ~sel;
					OP_REPORT_ALARM: next_q.report_alarm = q.report_alarm | sel;
					OP_EXIT_MODE: begin
						for (int i = 0; i < N; i++) begin
							if (sel[i]) begin
								next_q.exit_mode[i*MODE_W +: MODE_W] = cmd_mode;
							end
						end
					end
					default: next_q.enable = q.enable;
				endcase
			end
		end
		// Scanner drains one pending flag per cycle, lowest code first
		next_q.ev_valid = 1'b0;
		if (q.enable[q.ptr] && q.pend[q.ptr] != '0) begin
			for (int e = EV_W - 1; e >= 0; e--) begin
				if (q.pend[q.ptr][e]) begin
					found = 1'b1;
					code = 4'(e);
				end
			end
			next_q.ev_valid = found;
			next_q.ev_input = q.ptr;
			next_q.ev_code = code;
			next_q.pend[q.ptr][code] = 1'b0;
		end else begin
			next_q.ptr = (q.ptr == IW'(N - 1)) ? '0 : q.ptr + 1'b1;
		end
		// New events set flags after the clear so a set in the same cycle wins
		for (int i = 0; i < N; i++) begin
			if (!q.enable[i]) begin
				next_q.pend[i] = '0;
			end else begin
				if (ch_ev_secure[i]) begin
					next_q.pend[i][EV_SECURE] = 1'b1;
				end
				if (ch_ev_open[i]) begin
					next_q.pend[i][q.report_alarm[i] ? EV_ALARM_OPEN : EV_FORCED] = 1'b1;
				end
				if (ch_ev_held[i]) begin
					next_q.pend[i][q.report_alarm[i] ? EV_TOO_LONG : EV_HELD] = 1'b1;
				end
				if (ch_ev_exit[i]) begin
					next_q.pend[i][EV_EXIT] = 1'b1;
				end
				if (ch_ev_fault[i] && ch_fault[i] <= 3'h4) begin
					next_q.pend[i][EV_LINE_OPEN + 4'(ch_fault[i]) - 4'h1] = 1'b1;
				end
			end
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{enable: '1, exit_mode: {N{EXIT_MODE_RESET}}, door_time: DOOR_TIME_RESET,
				default: '0};
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// One channel per input
	for (genvar i = 0; i < N; i++) begin : g_chan
		input_channel u_chan (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.tick(q.tick),
			.enable(q.enable[i]),
			.polarity(q.polarity[i]),
			.exit_mode(q.exit_mode[i*MODE_W +: MODE_W]),
			.door_time(q.door_time),
			.ext_mask(tz_mask[i] | q.code_mask[i] | relay_actuated[i]),
			.held_open_timeout(held_open_timeout[i]),
			.contact_closed(contact_closed[i]),
			.exit_request(exit_request[i]),
			.line_fault(line_fault[i*FAULT_W +: FAULT_W]),
			.masked(input_masked[i]),
			.secure(ch_secure[i]),
			.fault(ch_fault[i]),
			.relay_trigger(ch_relay[i]),
			.ev_secure(ch_ev_secure[i]),
			.ev_open(ch_ev_open[i]),
			.ev_held(ch_ev_held[i]),
			.ev_exit(ch_ev_exit[i]),
			.ev_fault(ch_ev_fault[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_start_enabled;
		@(posedge core_clk) disable iff (!rst_n) $rose(rst_n) |-> q.enable == '1;
	endproperty
	a_start_enabled: assert property (p_start_enabled) else $error("inputs not enabled");

	property p_cmd_enable;
		@(posedge core_clk) disable iff (!rst_n)
			(wr && paddr == ADDR_COMMAND && cmd_op == OP_ENABLE && pwdata[11:8] == 4'h1)
			|=> q.enable[0];
	endproperty
	a_cmd_enable: assert property (p_cmd_enable) else $error("enable digit ignored");

	property p_cmd_disable;
		@(posedge core_clk) disable iff (!rst_n)
			(wr && paddr == ADDR_COMMAND && cmd_op == OP_DISABLE && pwdata[11:8] == 4'h1)
			|=> !q.enable[0];
	endproperty
	a_cmd_disable: assert property (p_cmd_disable) else $error("disable digit ignored");

	property p_pol_open;
		@(posedge core_clk) disable iff (!rst_n)
			(wr && paddr == ADDR_COMMAND && cmd_op == OP_NORM_OPEN)
			|=> (q.polarity & $past(sel)) == $past(sel);
	endproperty
	a_pol_open: assert property (p_pol_open) else $error("polarity not set");

	// Door style keeps the plain held-open code
	property p_door_style;
		@(posedge core_clk) disable iff (!rst_n)
			(ch_ev_held[1] && q.enable[1] && !q.report_alarm[1]) |=> q.pend[1][EV_HELD];
	endproperty
	a_door_style: assert property (p_door_style) else $error("held open not queued");

	property p_alarm_style;
		@(posedge core_clk) disable iff (!rst_n)
			(ch_ev_open[0] && q.enable[0] && q.report_alarm[0]) |=> q.pend[0][EV_ALARM_OPEN];
	endproperty
	a_alarm_style: assert property (p_alarm_style) else $error("alarm open not queued");

	property p_disabled_silent;
		@(posedge core_clk) disable iff (!rst_n) !q.enable[q.ptr] |=> !event_valid;
	endproperty
	a_disabled_silent: assert property (p_disabled_silent) else $error("disabled input reported");

	property p_disabled_relay;
		@(posedge core_clk) disable iff (!rst_n) !$past(q.enable[7]) |-> !relay_trigger[7];
	endproperty
	a_disabled_relay: assert property (p_disabled_relay) else $error("disabled input pulsed relay");

	property p_code_range;
		@(posedge core_clk) disable iff (!rst_n) event_valid |-> event_code <= EV_TOO_LONG;
	endproperty
	a_code_range: assert property (p_code_range) else $error("bad event code");

	property p_mode_write;
		@(posedge core_clk) disable iff (!rst_n)
			(wr && paddr == ADDR_EXIT_MODE) |=> q.exit_mode == $past(pwdata[N*MODE_W-1:0]);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("exit mode not stored");

	property p_mask_join;
		@(posedge core_clk) disable iff (!rst_n)
			(tz_mask[0] || relay_actuated[0] || q.code_mask[0]) |-> input_masked[0];
	endproperty
	a_mask_join: assert property (p_mask_join) else $error("mask source ignored");

	c_forced: cover property (@(posedge core_clk) disable iff (!rst_n)
		event_valid && event_code == EV_FORCED);
	c_alarm_open: cover property (@(posedge core_clk) disable iff (!rst_n)
		event_valid && event_code == EV_ALARM_OPEN);
	c_unmapped: cover property (@(posedge core_clk) disable iff (!rst_n) pslverr);
endmodule : alarm_input_supervisor

/* verif/door_field_model.sv */
// Field side model: door contacts and exit request devices behind the line modules.
// Assumes the bench tells it which doors are open and which contacts are normally open.
module door_field_model #(
	parameter int N = 8
) (
	input wire logic core_clk,
	input wire logic [N-1:0] door_open,
	input wire logic [N-1:0] norm_open,
	input wire logic [N-1:0] press,
	output logic [N-1:0] contact_closed,
	output logic [N-1:0] exit_request
);
	timeunit 1ns;
	timeprecision 1ps;

	// Secure contact rests closed unless wired normally open
	initial begin
		contact_closed = '1;
		exit_request = '0;
	end

	// Pins move just after the clock edge, asynchronous to the design's view
	always @(posedge core_clk) begin
		contact_closed <= door_open ^ ~norm_open;
		exit_request <= press;
	end
endmodule : door_field_model

/* verif/alarm_input_supervisor_tb.sv */
// Self-checking bench: APB setup, door and alarm events, masking, exit modes.
// Assumes the field model on the pins and a door time tick of 4 cycles.
module alarm_input_supervisor_tb;
	import supervisor_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [7:0] paddr = '0, door = '0, nopen = '0, press = '0, tzm = '0, rly = '0, hot = '0;
	logic [31:0] pwdata = '0, prdata, rd, r;
	logic [7:0] contact_closed, exit_request, relay_trigger, input_masked;
	logic [23:0] line_fault = '0;
	logic event_valid;
	logic [2:0] event_input;
	logic [3:0] event_code;
	logic [6:0] expq[$];
	logic [6:0] last = '1;
	int num_errors = 0, n_checks = 0, rcnt[8];

	// 250 MHz core clock
	always #2 core_clk = ~core_clk;

	alarm_input_supervisor #(.NUM_INPUTS(8), .TICK_CYCLES(4)) i_alarm_input_supervisor (
		.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.contact_closed(contact_closed), .exit_request(exit_request), .line_fault(line_fault),
		.tz_mask(tzm), .relay_actuated(rly), .held_open_timeout(hot),
		.relay_trigger(relay_trigger), .input_masked(input_masked), .event_valid(event_valid),
		.event_input(event_input), .event_code(event_code));

	door_field_model #(.N(8)) i_door_field_model (.core_clk(core_clk), .door_open(door),
		.norm_open(nopen), .press(press), .contact_closed(contact_closed),
		.exit_request(exit_request));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic results();
		if (num_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	task automatic hang();
		num_errors++;
		results();
	endtask : hang

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (i == 50) hang();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(n, rd, e);
	endtask : rdchk

	task automatic cmd(input logic [31:0] d);
		apb(1'b1, ADDR_COMMAND, d);
	endtask : cmd

	function automatic void exp_ev(input int i, input logic [3:0] c);
		expq.push_back({3'(i), c});
	endfunction : exp_ev

	// Let events settle, then wait for every expected one
	task automatic drain();
		int i;
		repeat (40) @(posedge core_clk);
		for (i = 0; i < 300 && expq.size() > 0; i++) @(posedge core_clk);
		if (expq.size() > 0) hang();
	endtask : drain

	////////////////////////////////////////////////////////////////////////////////
	// Event watcher; an exit grant that repeats the previous event of the same input merges
	always @(posedge core_clk) begin
		if (event_valid === 1'b1) begin
			if (!({event_input, event_code} == last && event_code == EV_EXIT)) begin
				check("event", {event_input, event_code}, expq.size() > 0 ? expq.pop_front() : 7'h7f);
			end
			last <= {event_input, event_code};
		end
	end

	// Relay pulse counters
	always @(posedge core_clk) begin
		for (int k = 0; k < 8; k++) begin
			if (relay_trigger[k] === 1'b1) rcnt[k]++;
		end
	end

	initial begin
		logic a, rl, rt;
		int f;
		void'($urandom(32'h0c8f));
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		// Reset values and an unmapped read
		rdchk("enable", ADDR_ENABLE, 32'hff);
		rdchk("polarity", ADDR_POLARITY, 32'h0);
		rdchk("report", ADDR_REPORT, 32'h0);
		rdchk("exit_mode", ADDR_EXIT_MODE, 32'h55555555);
		rdchk("door_time", ADDR_DOOR_TIME, {16'h0, DOOR_TIME_RESET});
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped_err", err, 1'b1);
		r = $urandom() & 32'hffff;
		apb(1'b1, ADDR_DOOR_TIME, r);
		rdchk("door_time_rw", ADDR_DOOR_TIME, r);
		r = $urandom();
		apb(1'b1, ADDR_EXIT_MODE, r);
		rdchk("exit_mode_rw", ADDR_EXIT_MODE, r);
		apb(1'b1, ADDR_EXIT_MODE, 32'h55555555);
		apb(1'b1, ADDR_DOOR_TIME, 32'd10);
		// Digit lists
		cmd(32'h65432102);
		rdchk("en_subset", ADDR_ENABLE, 32'hc0);
		cmd(32'h00432101);
		rdchk("en_list", ADDR_ENABLE, 32'hcf);
		cmd(32'h00876501);
		rdchk("en_all", ADDR_ENABLE, 32'hff);
		cmd(32'h00000107);
		rdchk("report_alarm", ADDR_REPORT, 32'h1);
		// Alarm style on input 0, door style on input 1
		for (int i = 0; i < 2; i++) begin
			exp_ev(i, i ? EV_FORCED : EV_ALARM_OPEN);
			door[i] <= 1'b1;
			drain();
			exp_ev(i, i ? EV_HELD : EV_TOO_LONG);
			hot[i] <= 1'b1;
			@(posedge core_clk);
			hot[i] <= 1'b0;
			drain();
			exp_ev(i, EV_SECURE);
			door[i] <= 1'b0;
			drain();
		end
		cmd(32'h00000106);
		rdchk("report_door", ADDR_REPORT, 32'h0);
		// Each mask source hides the forced report only
		for (int s = 0; s < 3; s++) begin
			tzm[2] <= (s == 0);
			rly[2] <= (s == 1);
			apb(1'b1, ADDR_CODE_MASK, {29'h0, s == 2, 2'b00});
			door[2] <= 1'b1;
			repeat (20) @(posedge core_clk);
			check("masked", input_masked[2], 1'b1);
			rdchk("status", ADDR_STATUS, 32'h04fb);
			exp_ev(2, EV_SECURE);
			door[2] <= 1'b0;
			drain();
		end
		tzm[2] <= 1'b0;
		rly[2] <= 1'b0;
		apb(1'b1, ADDR_CODE_MASK, 32'h0);
		// Normally open contact on input 4
		cmd(32'h00000502);
		nopen[4] <= 1'b1;
		cmd(32'h00000503);
		repeat (10) @(posedge core_clk);
		cmd(32'h00000501);
		rdchk("polarity_no", ADDR_POLARITY, 32'h10);
		exp_ev(4, EV_FORCED);
		door[4] <= 1'b1;
		drain();
		exp_ev(4, EV_SECURE);
		door[4] <= 1'b0;
		drain();
		exp_ev(4, EV_FORCED);
		cmd(32'h00000504);
		rdchk("polarity_nc", ADDR_POLARITY, 32'h0);
		drain();
		// Line faults still report while masked
		tzm[0] <= 1'b1;
		for (f = 1; f < 5; f++) begin
			exp_ev(0, 4'(EV_LINE_OPEN + f - 1));
			line_fault[2:0] <= 3'(f);
			drain();
		end
		cmd(32'h00000102);
		line_fault[2:0] <= 3'h0;
		tzm[0] <= 1'b0;
		repeat (10) @(posedge core_clk);
		cmd(32'h00000101);
		// Disabled input 7 ignores its exit request and reports nothing
		cmd(32'h00000815);
		cmd(32'h00000802);
		rcnt[7] = 0;
		press[7] <= 1'b1;
		door[7] <= 1'b1;
		drain();
		check("disabled_relay", rcnt[7], 0);
		check("disabled_mask", input_masked[7], 1'b0);
		// Every exit mode on input 3
		for (int m = 1; m < 10; m++) begin
			a = (m != 5);
			rl = (m inside {1, 3, 4, 6, 8});
			rt = (m inside {3, 8, 9});
			cmd(32'h00000405 | (m << 4));
			rcnt[3] = 0;
			if (a) exp_ev(3, EV_EXIT);
			press[3] <= 1'b1;
			repeat (8) @(posedge core_clk);
			check("exit_mask", input_masked[3], a);
			if (!a) exp_ev(3, EV_FORCED);
			door[3] <= 1'b1;
			repeat (24) @(posedge core_clk);
			press[3] <= 1'b0;
			for (f = 0; f < 300 && input_masked[3] === 1'b1; f++) @(posedge core_clk);
			if (f == 300) hang();
			exp_ev(3, EV_SECURE);
			door[3] <= 1'b0;
			drain();
			check("relay_pulses", rt ? (rcnt[3] > 1) : rcnt[3], rl);
		end
		results();
	end
endmodule : alarm_input_supervisor_tb
